// ### verilog/mtpt_tracker.sv
// missing tooth crank position tracker with phase input monitoring
`timescale 1ns/100ps
module mtpt_tracker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic crank_pin,
  input wire logic phase_input,
  input wire logic sync_enable,
  input wire logic four_stroke,
  input wire logic [mtpt_pkg::IDX_W-1:0] wheel_tooth_total,
  input wire logic [1:0] gap_tooth_total,
  input wire logic [mtpt_pkg::PER_W-1:0] minimum_rotation_rate,
  input wire logic [2:0] filter_time_us,
  input wire logic [mtpt_pkg::IDX_W-1:0] phase_shift_teeth,
  input wire logic [mtpt_pkg::IDX_W-1:0] phase_stretch_teeth,
  input wire logic error_flag_clear,
  output logic [mtpt_pkg::IDX_W-1:0] tooth_index_out,
  output logic lock_state,
  output logic rotation_state,
  output logic error_flag,
  output mtpt_pkg::mtpt_health_t phase_signal_health,
  output logic [mtpt_pkg::PER_W-1:0] tooth_period_out,
  output logic capture_trigger,
  output logic [mtpt_pkg::HIST_W-1:0] capture_history
);
  import mtpt_pkg::*;

  // ==========================================================
  // helpers
  // gap test in doubled units so that the threshold sits at
  // gap+0.5 intervals, half an interval short of a gap tooth (gap+1)
  function automatic logic gap_seen(input logic [PER_W-1:0] p,
                                    input logic [PER_W-1:0] lp,
                                    input logic [1:0] m);
    logic [PER_W+2:0] lhs;
    logic [PER_W+2:0] rhs;
    lhs = {2'b00, p, 1'b0};
    rhs = (PER_W+3)'(lp) * (PER_W+3)'({m, 1'b1});
    return lhs >= rhs;
  endfunction

  // phase levels at the last three gaps, newest in bit 0
  function automatic mtpt_health_t health_of(input logic [2:0] h);
    case (h)
      3'b010, 3'b101: return HL_NORMAL;
      3'b111: return HL_HIGH;
      3'b000: return HL_LOW;
      default: return HL_ERROR;
    endcase
  endfunction

  mtpt_regs_t q;
  mtpt_regs_t d;
  logic [1:0] pins;
  logic [FILT_W-1:0] filt_lim;
  logic [IDX_W-1:0] phys;
  logic [IDX_W-1:0] cyc_phys;
  logic [IDX_W-1:0] cyc_all;
  logic cfg_ok;

  assign pins = {phase_input, crank_pin};
  assign filt_lim = FILT_W'(int'(filter_time_us) * FILT_CYC_PER_US);
  assign phys = wheel_tooth_total - {6'h00, gap_tooth_total};
  assign cyc_phys = four_stroke ? {phys[IDX_W-2:0], 1'b0} : phys;
  assign cyc_all = four_stroke ?
                   {wheel_tooth_total[IDX_W-2:0], 1'b0} : wheel_tooth_total;
  // a gap of zero or three teeth never lets the tracker start
  assign cfg_ok = (gap_tooth_total >= GAP_MIN) &&
                  (gap_tooth_total <= GAP_MAX) &&
                  (wheel_tooth_total > {6'h00, gap_tooth_total});

  // ==========================================================
  // next state
  always_comb begin
    logic tick;
    logic tooth;
    logic rise_p;
    logic stalled;
    logic is_gap;
    logic cam_lvl;
    logic last_phys;
    logic err_set;
    logic lose;
    logic [IDX_W-1:0] pos;
    logic [2:0] camh_n;
    tick = 1'b0;
    tooth = 1'b0;
    rise_p = 1'b0;
    stalled = 1'b0;
    is_gap = 1'b0;
    cam_lvl = 1'b0;
    last_phys = 1'b0;
    err_set = 1'b0;
    lose = 1'b0;
    pos = '0;
    camh_n = '0;
    d = q;
    d.trig = 1'b0;

    // three-stage sync and integrating filter per input; the
    // count rises while the agreed level differs and sinks back
    // while it matches, so a burst of noise must outlast the limit
    for (int i = 0; i < 2; i++) begin
      d.sy[i] = {q.sy[i][1:0], pins[i]};
      if (q.sy[i][1] == q.sy[i][2]) begin
        if (q.sy[i][2] != q.filt[i]) begin
          if (q.fcnt[i] >= filt_lim) begin
            d.filt[i] = q.sy[i][2];
            d.fcnt[i] = '0;
          end else begin
            d.fcnt[i] = q.fcnt[i] + 1'b1;
          end
        end else if (q.fcnt[i] != '0) begin
          d.fcnt[i] = q.fcnt[i] - 1'b1;
        end
      end
    end
    tooth = d.filt[CH_CRANK] & ~q.filt[CH_CRANK];
    rise_p = d.filt[CH_PHASE] & ~q.filt[CH_PHASE];

    // 40 MHz timer tick from the 200 MHz clock
    tick = (q.div == TICK_LAST);
    d.div = tick ? '0 : q.div + 3'h1;

    // tooth interval, saturating instead of wrapping
    stalled = (q.per >= minimum_rotation_rate) || (q.per == PER_MAX);
    if (tooth) begin
      d.per = '0;
    end else if (tick && q.per != PER_MAX) begin
      d.per = q.per + 1'b1;
    end
    if (tooth) begin
      d.mtmr = '0;
    end else if (tick && q.mtmr != PER_MAX) begin
      d.mtmr = q.mtmr + 1'b1;
    end

    // rotation state needs two fast teeth in a row
    if (tooth) begin
      d.have_prev = 1'b1;
      if (q.have_prev && !stalled) begin
        d.spin = 1'b1;
      end
    end
    if (stalled) begin
      d.spin = 1'b0;
      d.have_prev = 1'b0;
    end

    // phase delay then stretch, counted in crank teeth
    cam_lvl = (phase_shift_teeth == '0) ? q.filt[CH_PHASE] :
              (q.str != '0);
    if (tooth) begin
      if (q.shf != '0) begin
        d.shf = q.shf - 1'b1;
        if (q.shf == 8'h01) begin
          d.str = {1'b0, phase_stretch_teeth} + 9'h001;
        end
      end
      if (q.str != '0 && q.shf != 8'h01) begin
        d.str = q.str - 1'b1;
      end
    end
    if (rise_p && phase_shift_teeth != '0) begin
      d.shf = phase_shift_teeth;
    end

    is_gap = gap_seen(q.per, q.lastp, gap_tooth_total);
    // outside lock every real interval is taken, so a stray edge
    // cannot pin the reference low; in lock gaps are left out
    if (tooth && q.have_prev && (!is_gap || q.st != ST_SYNC)) begin
      d.lastp = q.per;
    end
    pos = (four_stroke && q.idx >= wheel_tooth_total) ?
          q.idx - wheel_tooth_total : q.idx;
    last_phys = (pos >= phys - 8'h01);
    camh_n = {q.camh[1:0], cam_lvl};

    if (error_flag_clear) begin
      d.err = 1'b0;
    end

    // lock sequencing
    case (q.st)
      ST_STOP: begin
        if (q.spin && sync_enable && cfg_ok && !q.err) begin
          d.st = ST_COUNT;
          d.cnt = '0;
        end
      end
      ST_COUNT: begin
        if (tooth) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt >= cyc_phys - 8'h01) begin
            d.st = ST_SEARCH;
          end
        end
      end
      ST_SEARCH: begin
        // 2-stroke ignores phase; 4-stroke waits for a high gap
        if (tooth && is_gap && (!four_stroke || cam_lvl)) begin
          d.st = ST_SYNC;
          d.idx = '0;
          d.camh = {q.camh[1:0], 1'b1};
          d.ncam = 2'h1;
        end
      end
      ST_SYNC: begin
        if (tooth) begin
          if (is_gap != last_phys) begin
            err_set = 1'b1;
          end else if (is_gap) begin
            // once locked only the gap keeps position
            d.idx = (!four_stroke || q.idx >= wheel_tooth_total) ?
                    '0 : wheel_tooth_total;
            if (four_stroke) begin
              d.camh = camh_n;
              d.ncam = (q.ncam == 2'h3) ? q.ncam : q.ncam + 2'h1;
              if (q.ncam >= 2'h2 && health_of(camh_n) == HL_ERROR) begin
                err_set = 1'b1;
              end
            end
          end else begin
            d.idx = q.idx + 8'h01;
          end
        end else if (last_phys && pos < wheel_tooth_total - 8'h01 &&
                     q.lastp != '0 && q.mtmr >= q.lastp) begin
          d.idx = q.idx + 8'h01;
          d.mtmr = '0;
        end
      end
      default: begin
        d.st = ST_STOP;
      end
    endcase
    if (d.idx >= cyc_all && d.st == ST_SYNC) begin
      err_set = 1'b1;
    end

    // every loss: index zero, stopped; errors also latch the flag
    if (err_set) begin
      d.err = 1'b1;
      lose = 1'b1;
    end
    if (q.st != ST_STOP && (stalled || !sync_enable || !cfg_ok)) begin
      lose = 1'b1;
    end
    if (lose) begin
      d.st = ST_STOP;
      d.idx = '0;
      d.cnt = '0;
      d.trig = (q.st == ST_SYNC);
    end

    // edge history, frozen at a loss of lock so the lead-up stays visible
    if (d.trig) begin
      d.frozen = 1'b1;
    end else if (d.st == ST_SYNC) begin
      d.frozen = 1'b0;
    end
    if (!q.frozen && d.filt != q.filt) begin
      d.hist = {q.hist[HIST_W-3:0], d.filt};
    end
    d.lock = (d.st == ST_SYNC);
    d.hl = (q.ncam == 2'h3) ? health_of(q.camh) : HL_NORMAL;
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign tooth_index_out = q.idx;
  assign lock_state = q.lock;
  assign rotation_state = q.spin;
  assign error_flag = q.err;
  assign phase_signal_health = q.hl;
  assign tooth_period_out = q.lastp;
  assign capture_trigger = q.trig;
  assign capture_history = q.hist;

  // ==========================================================
  // checks
  stop_index_a: assert property (@(posedge mclk) disable iff (rst)
    q.st != ST_SYNC |-> q.idx == '0)
    else $error("index not zero while unlocked");
  err_hold_a: assert property (@(posedge mclk) disable iff (rst)
    error_flag |-> q.st == ST_STOP)
    else $error("tracker left stop with error latched");
  stall_drop_a: assert property (@(posedge mclk) disable iff (rst)
    lock_state && q.per >= minimum_rotation_rate |=> !lock_state)
    else $error("lock kept below minimum rotation rate");
  per_sat_a: assert property (@(posedge mclk) disable iff (rst)
    q.per == PER_MAX && !(d.filt[0] && !q.filt[0]) |=> q.per == PER_MAX)
    else $error("interval counter wrapped");
  idx_range_a: assert property (@(posedge mclk) disable iff (rst)
    $stable(wheel_tooth_total) && $stable(four_stroke) |->
    tooth_index_out < cyc_all || tooth_index_out == '0)
    else $error("tooth index out of range");
  gap_cfg_a: assert property (@(posedge mclk) disable iff (rst)
    !cfg_ok ##1 !cfg_ok |-> q.st == ST_STOP)
    else $error("tracker running with bad gap size");
  filter_a: assert property (@(posedge mclk) disable iff (rst)
    q.filt[0] != $past(q.filt[0]) |->
    $past(q.fcnt[0]) >= $past(filt_lim))
    else $error("filtered crank changed before filter time");
  err_loss_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(error_flag) |-> !lock_state && tooth_index_out == '0)
    else $error("error flag without loss of lock");
  tick_div_a: assert property (@(posedge mclk) disable iff (rst)
    q.per != '0 && q.per != $past(q.per) |->
    $past(q.div) == TICK_LAST && q.per == $past(q.per) + 1'b1)
    else $error("interval timer not at 40 MHz");
  trig_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(lock_state) |-> capture_trigger ##1 !capture_trigger)
    else $error("no capture trigger on lock loss");
endmodule

// ### verilog/mtpt_pkg.sv
// constants, types and state layout of the gap pattern tracker
// Contract
// - lock drops when rotation is slower than the minimum rotation rate
// - tooth interval timed by a 24-bit counter ticking at 40 MHz
// - missing or extra crank or phase pulses drop lock as an error
// - any lock loss zeroes the tooth index and shows stopped
// - an error loss also raises the error flag
// - after an error no relock until error_flag_clear is pulsed
// - filter discards pulses no wider than filter time, 1 to 5 us typical
// - capture trigger on lock loss, keeping the edge samples before it
// - gap size accepts only one or two missing teeth
// - physical teeth per turn are tooth total minus gap size
// - 2-stroke covers 360 degrees and ignores the phase input
// - 2-stroke: index zero is first tooth after each gap, up to N-1
// - index keeps advancing at each missing tooth position in a gap
// - 4-stroke: index runs to 2N-1, zero after gap with phase high
// - 4-stroke: phase used only for initial lock, then gaps alone
// - phase level checked each gap: normal, always high, low or error
// - several phase pulses per cycle allowed if gap levels are right
// - phase signal delayed and then stretched by configured teeth; the code skips the stretch when the delay is zero
// - delayed phase signal is one tooth wide before the stretch
// - after spinning starts, one full cycle of teeth before gap search
// - integrating filter rejects short high and low going pulses
package mtpt_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int TIMER_HZ = 40_000_000;
  localparam int TICK_DIV = CLK_HZ / TIMER_HZ;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
  localparam int PER_W = 24;
  localparam logic [PER_W-1:0] PER_MAX = 24'hffffff;
  localparam int FILT_W = 11;
  localparam int FILT_CYC_PER_US = CLK_HZ / 1_000_000;
  // ==========================================================
  // widths and limits
  localparam int IDX_W = 8;
  localparam int HIST_W = 32;
  localparam logic [1:0] GAP_MIN = 2'h1;
  localparam logic [1:0] GAP_MAX = 2'h2;
  localparam int CH_CRANK = 0;
  localparam int CH_PHASE = 1;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_COUNT = 2'b01,
    ST_SEARCH = 2'b10,
    ST_SYNC = 2'b11
  } mtpt_state_t;
  typedef enum logic [1:0] {
    HL_NORMAL = 2'b00,
    HL_HIGH = 2'b01,
    HL_LOW = 2'b10,
    HL_ERROR = 2'b11
  } mtpt_health_t;
  typedef struct packed {
    logic [1:0][2:0] sy;
    logic [1:0][FILT_W-1:0] fcnt;
    logic [1:0] filt;
    logic [2:0] div;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] lastp;
    logic [PER_W-1:0] mtmr;
    logic have_prev;
    logic spin;
    logic err;
    logic lock;
    logic trig;
    logic frozen;
    mtpt_state_t st;
    logic [IDX_W-1:0] cnt;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] shf;
    logic [IDX_W:0] str;
    logic [2:0] camh;
    logic [1:0] ncam;
    mtpt_health_t hl;
    logic [HIST_W-1:0] hist;
  } mtpt_regs_t;
  localparam mtpt_regs_t REGS_RST = '0;
endpackage

// ### sim/mtpt_sensor_model.sv
// crank and phase sensor model for the gap pattern tracker bench
`timescale 1ns/100ps
module mtpt_sensor_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic four_stroke,
  input wire logic extra,
  input wire logic [15:0] period,
  input wire logic [15:0] glitch,
  input wire logic [7:0] total,
  input wire logic [1:0] gap,
  output logic crank_pin,
  output logic phase_input
);
  logic [15:0] cyc;
  logic [8:0] pos;
  logic [8:0] span;
  logic pend;
  logic tooth;
  logic dip;
  logic xtra;

  // ==========================================================
  // wheel geometry
  assign span = four_stroke ? 9'(2 * total) : 9'(total);
  // no tooth in the last gap slots of each turn
  assign tooth = (pos % 9'(total)) < (9'(total) - 9'(gap)) &&
    cyc < period / 2;
  assign dip = glitch != 16'h0 && cyc >= period / 8 &&
    cyc < period / 8 + glitch;
  assign xtra = pend && pos == 9'h3 && cyc >= 3 * period / 4 &&
    cyc < 7 * period / 8;

  // slot timing; a stopped wheel leaves both lines low
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc <= 16'h0;
      pos <= 9'h0;
      pend <= 1'b0;
      crank_pin <= 1'b0;
      phase_input <= 1'b0;
    end else if (!run) begin
      cyc <= 16'h0;
      crank_pin <= 1'b0;
      phase_input <= 1'b0;
      pend <= pend | extra;
    end else begin
      // >= so that a shortened period never lets the count run away
      cyc <= (cyc >= period - 1) ? 16'h0 : cyc + 16'h1;
      if (cyc >= period - 1) begin
        pos <= (pos >= span - 1) ? 9'h0 : pos + 9'h1;
      end
      if (extra) begin
        pend <= 1'b1;
      end else if (xtra && cyc == 7 * period / 8 - 1) begin
        pend <= 1'b0;
      end
      crank_pin <= (tooth && !dip) || xtra;
      // high over every second gap; toggles freely in 2-stroke
      phase_input <= four_stroke ? (pos >= span - 9'(gap) - 9'h2 ||
        pos == 9'h0) : pos[0];
    end
  end
endmodule

// ### sim/test_mtpt_tracker.sv
// self-checking bench of the gap pattern tracker
`timescale 1ns/100ps
module test_mtpt_tracker;
  import mtpt_pkg::*;
  logic mclk, rst, run, extra, sync_enable, four_stroke, error_flag_clear;
  logic crank_pin, phase_input, lock_state, rotation_state, error_flag;
  logic capture_trigger;
  logic [15:0] period, glitch;
  logic [2:0] filter_time_us;
  logic [IDX_W-1:0] tooth_index_out, mx, shift, stretch;
  logic [1:0] gap_cfg;
  logic [PER_W-1:0] tooth_period_out;
  logic [HIST_W-1:0] capture_history, hsave;
  mtpt_health_t phase_signal_health;
  int miscompares, n_tests, cycles, t;

  mtpt_sensor_model mtpt_sensor_model_inst (.mclk(mclk), .rst(rst),
    .run(run), .four_stroke(four_stroke), .extra(extra), .period(period),
    .glitch(glitch), .total(8'h0c), .gap(2'h2), .crank_pin(crank_pin),
    .phase_input(phase_input));
  // minimum rate as a period of 2048 ticks keeps the gap well clear
  mtpt_tracker mtpt_tracker_inst (.mclk(mclk), .rst(rst),
    .crank_pin(crank_pin), .phase_input(phase_input),
    .sync_enable(sync_enable), .four_stroke(four_stroke),
    .wheel_tooth_total(8'h0c), .gap_tooth_total(gap_cfg),
    .minimum_rotation_rate(24'h000800), .filter_time_us(filter_time_us),
    .phase_shift_teeth(shift), .phase_stretch_teeth(stretch),
    .error_flag_clear(error_flag_clear), .tooth_index_out(tooth_index_out),
    .lock_state(lock_state), .rotation_state(rotation_state),
    .error_flag(error_flag), .phase_signal_health(phase_signal_health),
    .tooth_period_out(tooth_period_out), .capture_trigger(capture_trigger),
    .capture_history(capture_history));

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_lock(input logic v, input int lim, output int n);
    n = 0;
    while (lock_state !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check("lock_state", 32'(lock_state), 32'(v));
  endtask

  // largest index over a span; the caller's check compares it with the top index
  task automatic span_max(input int n);
    mx = '0;
    repeat (n) begin
      @(negedge mclk);
      if (tooth_index_out > mx) begin
        mx = tooth_index_out;
      end
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_filter();
    @(posedge mclk);
    filter_time_us <= 3'h1;
    period <= 16'd1600;
    glitch <= 16'd150;
    run <= 1'b1;
    repeat (6400) @(negedge mclk);
    check("rotation_state", 32'(rotation_state), 32'h1);
    // a 150-cycle dip inside each tooth must not shorten the interval;
    // the 200-cycle lead-in alone is too short to pass the filter
    check("period_near_320", 32'(tooth_period_out >= 24'd319 &&
      tooth_period_out <= 24'd321), 32'h1);
    @(posedge mclk);
    filter_time_us <= 3'h0;
    glitch <= 16'h0;
    period <= 16'd200;
    $display("done filter");
  endtask

  task automatic test_two_stroke();
    @(posedge mclk);
    sync_enable <= 1'b1;
    wait_lock(1'b1, 12000, t);
    check("count_before_search", 32'(t >= 2000), 32'h1);
    check("index_at_lock", 32'(tooth_index_out), 32'h0);
    span_max(4800);
    check("index_top", 32'(mx), 32'd11);
    check("error_flag", 32'(error_flag), 32'h0);
    $display("done two stroke");
  endtask

  task automatic test_error();
    @(posedge mclk);
    extra <= 1'b1;
    @(posedge mclk);
    extra <= 1'b0;
    wait_lock(1'b0, 4800, t);
    check("error_flag", 32'(error_flag), 32'h1);
    check("index_on_loss", 32'(tooth_index_out), 32'h0);
    repeat (4800) @(negedge mclk);
    check("held_unlocked", 32'(lock_state), 32'h0);
    @(posedge mclk);
    error_flag_clear <= 1'b1;
    @(posedge mclk);
    error_flag_clear <= 1'b0;
    wait_lock(1'b1, 9000, t);
    check("error_cleared", 32'(error_flag), 32'h0);
    $display("done error");
  endtask

  task automatic test_stall();
    @(posedge mclk);
    run <= 1'b0;
    wait_lock(1'b0, 12000, t);
    check("trigger", 32'(capture_trigger), 32'h1);
    hsave = capture_history;
    check("history_last", 32'(capture_history[1:0]), 32'h0);
    check("rotation_state", 32'(rotation_state), 32'h0);
    check("index_on_loss", 32'(tooth_index_out), 32'h0);
    check("error_flag", 32'(error_flag), 32'h0);
    @(negedge mclk);
    check("trigger_end", 32'(capture_trigger), 32'h0);
    $display("done stall");
  endtask

  task automatic test_four_stroke();
    @(posedge mclk);
    four_stroke <= 1'b1;
    run <= 1'b1;
    // still counting teeth before the gap search here, so the history must stay as frozen
    repeat (1000) @(negedge mclk);
    check("history_frozen", capture_history, hsave);
    wait_lock(1'b1, 20000, t);
    check("index_at_lock", 32'(tooth_index_out), 32'h0);
    span_max(9600);
    check("index_top", 32'(mx), 32'd23);
    check("history_resumes", 32'(capture_history != hsave), 32'h1);
    check("health", 32'(phase_signal_health), 32'(HL_NORMAL));
    check("error_flag", 32'(error_flag), 32'h0);
    @(posedge mclk);
    sync_enable <= 1'b0;
    wait_lock(1'b0, 10, t);
    check("no_error_drop", 32'(error_flag), 32'h0);
    check("index_on_loss", 32'(tooth_index_out), 32'h0);
    $display("done four stroke");
  endtask

  // bad gap size holds the tracker off; then the phase only reaches
  // the high gap through the one-tooth delay and its stretch
  task automatic test_phase_shift();
    @(posedge mclk);
    gap_cfg <= 2'h0;
    shift <= 8'h01;
    stretch <= 8'h01;
    sync_enable <= 1'b1;
    repeat (3000) @(negedge mclk);
    check("bad_gap_unlocked", 32'(lock_state), 32'h0);
    check("bad_gap_no_error", 32'(error_flag), 32'h0);
    @(posedge mclk);
    gap_cfg <= 2'h2;
    wait_lock(1'b1, 20000, t);
    check("index_at_lock", 32'(tooth_index_out), 32'h0);
    span_max(4800);
    check("index_top", 32'(mx), 32'd23);
    check("health", 32'(phase_signal_health), 32'(HL_NORMAL));
    check("error_flag", 32'(error_flag), 32'h0);
    $display("done phase shift");
  endtask

  // ==========================================================
  // clock, cycle ceiling and main sequence
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // the tests need about 69000 cycles; the ceiling cuts a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    extra = 1'b0;
    sync_enable = 1'b0;
    four_stroke = 1'b0;
    error_flag_clear = 1'b0;
    filter_time_us = 3'h0;
    period = 16'd200;
    glitch = 16'h0;
    gap_cfg = 2'h2;
    shift = 8'h00;
    stretch = 8'h00;
    hsave = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("lock_reset", 32'(lock_state), 32'h0);
    check("index_reset", 32'(tooth_index_out), 32'h0);
    test_filter();
    test_two_stroke();
    test_error();
    test_stall();
    test_four_stroke();
    test_phase_shift();
    complete_run();
  end
endmodule
